// *** arb_pkg.sv ***
// Constants and types for the stand-alone arbitration and reset block
package arb_pkg;
  localparam logic [7:0] CTRL_ADDR      = 8'h00;
  localparam logic [7:0] STATUS_ADDR    = 8'h04;
  localparam int         SEP_USB_BIT    = 7;
  localparam logic [7:0] CTRL_RESET     = 8'h00;
  localparam logic [1:0] RESP_OKAY      = 2'b00;
  localparam logic [1:0] RESP_SLVERR    = 2'b10;
  localparam int         CLK_PERIOD_NS  = 40;
  localparam int         RESET_HOLD_NS  = 1000000;
  // Least time, so round up
  localparam int         RESET_HOLD_CYCLES =
    (RESET_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [1:0] MAX_SERVES     = 2'd3;
  localparam int         NUM_MASTERS    = 5;
  localparam int         USB_IDX        = 2;
  typedef enum logic [2:0] {
    ST_BRIDGE,
    ST_REVOKE,
    ST_SAMPLE,
    ST_BUSY,
    ST_SERVE
  } arb_state_t;
endpackage

// *** standalone_pci_arbitration_reset.sv ***
// PCI arbitration options, bridge grant/busy handshake and reset sequencing
//
// Register access over AXI4-Lite and the register offsets are this design's own decisions.
`timescale 1ns/10ps
// What this block does
// - Strap low disables internal arbiter, repurposes pins
// - External mode: request bus for DMA, IDE, USB
// - Grant without pending request means bus parking
// - Control bit moves USB to secondary pair
// - RTC square wave out only when arbiter disabled
// - Internal arbiter parks grant on the bridge
// - Revoke: drive deasserted one clock, then release
// - No busy seen: grant highest priority requester
// - While bridge busy, grant no other master
// - At most three requests served before bridge regrant
// - Split strap low: separate grant and busy
// - Power-good low resets logic, CPU, PCI per strap
// - Hold CPU and PCI reset 1 ms after power-good
// - Strap low latched: PCI reset becomes input
// - External PCI reset resets logic, inverted to CPU
module standalone_pci_arbitration_reset #(
  parameter int unsigned RESET_HOLD = arb_pkg::RESET_HOLD_CYCLES
) (
  input  wire logic       aclk,
  input  wire logic       aresetn,
  input  wire logic [7:0] awaddr,
  input  wire logic       awvalid,
  output logic            awready,
  input  wire logic [31:0] wdata,
  input  wire logic [3:0] wstrb,
  input  wire logic       wvalid,
  output logic            wready,
  output logic [1:0]      bresp,
  output logic            bvalid,
  input  wire logic       bready,
  input  wire logic [7:0] araddr,
  input  wire logic       arvalid,
  output logic            arready,
  output logic [31:0]     rdata,
  output logic [1:0]      rresp,
  output logic            rvalid,
  input  wire logic       rready,
  input  wire logic       arbiter_disable_strap,
  input  wire logic       grant_busy_split_strap,
  input  wire logic       reset_source_strap,
  input  wire logic       power_good,
  input  wire logic       pci_reset_line_in,
  output logic            pci_reset_line_out,
  output logic            pci_reset_line_oe,
  output logic            cpu_reset_out,
  output logic            logic_reset,
  output logic            isa_reset,
  input  wire logic       dma_request,
  input  wire logic       ide_request,
  input  wire logic       usb_request,
  input  wire logic [1:0] master_request,
  output logic            dma_grant,
  output logic            ide_grant,
  output logic            usb_grant,
  output logic [1:0]      master_grant,
  output logic            primary_bus_request,
  input  wire logic       primary_bus_grant,
  output logic            secondary_bus_request,
  input  wire logic       secondary_bus_grant,
  output logic            bus_parked,
  input  wire logic       combined_grant_busy_in,
  output logic            combined_grant_busy_out,
  output logic            combined_grant_busy_oe,
  output logic            bridge_grant,
  input  wire logic       bridge_busy,
  input  wire logic       rtc_square_in,
  output logic            rtc_square_out,
  output logic            rtc_square_oe
);
  import arb_pkg::*;

  logic                   arb_off;
  logic                   split;
  logic                   ext_mode;
  logic [31:0]            hold_cnt;
  logic                   hold_done;
  logic                   rst_arb;
  logic [7:0]             ctrl;
  logic                   sep;
  logic [NUM_MASTERS-1:0] req;
  logic [NUM_MASTERS-1:0] grant;
  logic [NUM_MASTERS-1:0] next_grant;
  logic [NUM_MASTERS-1:0] ext_grant;
  arb_state_t             state;
  arb_state_t             next_state;
  logic [1:0]             serves;
  logic [1:0]             next_serves;
  logic                   busy_seen;
  logic                   prim_req;
  logic                   aw_held;
  logic                   w_held;
  logic [7:0]             aw_addr_q;
  logic [7:0]             wdata_q;
  logic                   wstrb_q;
  logic                   wr_fire;

  // Lowest index wins: DMA, IDE, USB, then other masters
  function automatic logic [NUM_MASTERS-1:0] pick(input logic [NUM_MASTERS-1:0] r);
    pick = r & (~r + 5'd1);
  endfunction

  function automatic logic mapped(input logic [7:0] a);
    mapped = (a[7:2] == CTRL_ADDR[7:2]) || (a[7:2] == STATUS_ADDR[7:2]);
  endfunction

  assign rst_arb   = !aresetn || logic_reset;
  assign hold_done = hold_cnt >= RESET_HOLD;
  assign sep       = ctrl[SEP_USB_BIT];
  assign req       = {master_request, usb_request, ide_request, dma_request};
  assign prim_req  = dma_request || ide_request || (usb_request && !sep);
  assign busy_seen = split ? bridge_busy : combined_grant_busy_in;
  assign dma_grant    = grant[0];
  assign ide_grant    = grant[1];
  assign usb_grant    = grant[USB_IDX];
  assign master_grant = grant[4:3];

  ////////////////////////////////////////////////////////////////////////////
  // Reset sequencing

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      hold_cnt           <= '0;
      logic_reset        <= 1'b1;
      isa_reset          <= 1'b1;
      cpu_reset_out      <= 1'b1;
      pci_reset_line_oe  <= 1'b0;
      pci_reset_line_out <= 1'b0;
      ext_mode           <= 1'b0;
      arb_off            <= 1'b0;
      split              <= 1'b0;
    end else if (!power_good) begin
      hold_cnt          <= '0;
      logic_reset       <= 1'b1;
      isa_reset         <= 1'b1;
      cpu_reset_out     <= 1'b1;
      // Last value before power-good rises is the latched one
      pci_reset_line_oe <= reset_source_strap;
      ext_mode          <= !reset_source_strap;
      arb_off           <= !arbiter_disable_strap;
      split             <= !grant_busy_split_strap;
    end else if (!hold_done) begin
      hold_cnt          <= hold_cnt + 32'd1;
      logic_reset       <= 1'b1;
      isa_reset         <= 1'b1;
      cpu_reset_out     <= 1'b1;
      pci_reset_line_oe <= !ext_mode;
    end else begin
      // Agent must hold it long enough for the keyboard core
      logic_reset       <= ext_mode && !pci_reset_line_in;
      isa_reset         <= ext_mode && !pci_reset_line_in;
      cpu_reset_out     <= ext_mode && !pci_reset_line_in;
      pci_reset_line_oe <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Arbitration

  always_comb begin
    ext_grant = '0;
    if (primary_bus_grant)
      ext_grant = pick({2'b00, usb_request && !sep, ide_request, dma_request});
    if (sep && secondary_bus_grant && usb_request)
      ext_grant[USB_IDX] = 1'b1;
  end

  always_comb begin
    next_state  = state;
    next_grant  = grant;
    next_serves = serves;
    unique case (state)
      ST_BRIDGE: if (|req)
        next_state = ST_REVOKE;
      ST_REVOKE:
        next_state = ST_SAMPLE;
      ST_SAMPLE: begin
        // Bridge answers in this cycle if it keeps the bus
        if (busy_seen) begin
          next_state = ST_BUSY;
        end else if (|req) begin
          next_state  = ST_SERVE;
          next_grant  = pick(req);
          next_serves = 2'd1;
        end else begin
          next_state = ST_BRIDGE;
        end
      end
      ST_BUSY: begin
        // Bus idle not checked after busy drops
        if (!busy_seen) begin
          if (|req) begin
            next_state  = ST_SERVE;
            next_grant  = pick(req);
            next_serves = 2'd1;
          end else begin
            next_state = ST_BRIDGE;
          end
        end
      end
      ST_SERVE: begin
        if (!(|(grant & req))) begin
          if (|req && serves < MAX_SERVES) begin
            next_grant  = pick(req);
            next_serves = serves + 2'd1;
          end else begin
            next_state = ST_BRIDGE;
            next_grant = '0;
          end
        end
      end
    endcase
    if (arb_off) begin
      next_state  = ST_BRIDGE;
      next_serves = '0;
      next_grant  = ext_grant;
    end
  end

  always_ff @(posedge aclk) begin
    if (rst_arb) begin
      state  <= ST_BRIDGE;
      grant  <= '0;
      serves <= '0;
    end else begin
      state  <= next_state;
      grant  <= next_grant;
      serves <= next_serves;
    end
  end

  // Pin drivers follow the next state so they line up with it
  always_ff @(posedge aclk) begin
    if (rst_arb) begin
      combined_grant_busy_out <= 1'b1;
      combined_grant_busy_oe  <= !arb_off && !split;
      bridge_grant            <= !arb_off && split;
      primary_bus_request     <= 1'b0;
      secondary_bus_request   <= 1'b0;
      bus_parked              <= 1'b0;
    end else begin
      combined_grant_busy_out <= next_state == ST_BRIDGE;
      combined_grant_busy_oe  <= !arb_off && !split &&
                                 (next_state == ST_BRIDGE || next_state == ST_REVOKE);
      bridge_grant            <= !arb_off && split && next_state == ST_BRIDGE;
      primary_bus_request     <= arb_off && prim_req;
      secondary_bus_request   <= arb_off && sep && usb_request;
      bus_parked              <= arb_off && primary_bus_grant && !prim_req;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rtc_square_out <= 1'b0;
      rtc_square_oe  <= 1'b0;
    end else begin
      rtc_square_out <= rtc_square_in;
      rtc_square_oe  <= arb_off;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // AXI4-Lite slave

  assign wr_fire = aw_held && w_held && !bvalid;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awready   <= 1'b1;
      wready    <= 1'b1;
      aw_held   <= 1'b0;
      w_held    <= 1'b0;
      bvalid    <= 1'b0;
      bresp     <= RESP_OKAY;
      aw_addr_q <= '0;
      wdata_q   <= '0;
      wstrb_q   <= 1'b0;
    end else begin
      if (awvalid && awready) begin
        aw_held   <= 1'b1;
        awready   <= 1'b0;
        aw_addr_q <= awaddr;
      end
      if (wvalid && wready) begin
        w_held  <= 1'b1;
        wready  <= 1'b0;
        wdata_q <= wdata[7:0];
        wstrb_q <= wstrb[0];
      end
      if (wr_fire) begin
        bvalid <= 1'b1;
        bresp  <= mapped(aw_addr_q) ? RESP_OKAY : RESP_SLVERR;
      end else if (bvalid && bready) begin
        bvalid  <= 1'b0;
        aw_held <= 1'b0;
        w_held  <= 1'b0;
        awready <= 1'b1;
        wready  <= 1'b1;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (rst_arb)
      ctrl <= CTRL_RESET;
    else if (wr_fire && wstrb_q && aw_addr_q[7:2] == CTRL_ADDR[7:2])
      ctrl <= wdata_q;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready <= 1'b1;
      rvalid  <= 1'b0;
      rdata   <= '0;
      rresp   <= RESP_OKAY;
    end else if (arvalid && arready) begin
      arready <= 1'b0;
      rvalid  <= 1'b1;
      rresp   <= mapped(araddr) ? RESP_OKAY : RESP_SLVERR;
      if (araddr[7:2] == CTRL_ADDR[7:2])
        rdata <= {24'h000000, ctrl};
      else if (araddr[7:2] == STATUS_ADDR[7:2])
        rdata <= {16'h0000, grant, 1'b0, serves, 1'b0, state,
                  cpu_reset_out, ext_mode, split, arb_off};
      else
        rdata <= '0;
    end else if (rvalid && rready) begin
      rvalid  <= 1'b0;
      arready <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  a_rtc_route: assert property (1 |=> rtc_square_oe == $past(arb_off))
    else $error("RTC square wave routing wrong");
  a_bridge_park: assert property (state == ST_BRIDGE && !arb_off && !split && $stable(arb_off)
      && $stable(split) |-> combined_grant_busy_oe && combined_grant_busy_out)
    else $error("Bridge not granted in idle state");
  a_revoke_pulse: assert property (combined_grant_busy_oe && !combined_grant_busy_out
      |=> !combined_grant_busy_oe)
    else $error("Revoke not a single clock");
  a_sample_grant: assert property (state == ST_SAMPLE && !busy_seen && |req && !rst_arb
      && !arb_off |=> state == ST_SERVE && $onehot(grant))
    else $error("No grant after unanswered revoke");
  a_busy_block: assert property (state == ST_BUSY && busy_seen && !rst_arb
      |=> grant == '0 ##0 state == ST_BUSY)
    else $error("Grant while bridge busy");
  a_serve_limit: assert property (state == ST_SERVE && serves == MAX_SERVES && !(|(grant & req)) && !rst_arb
      && !arb_off |=> state == ST_BRIDGE && grant == '0)
    else $error("Too many requests served");
  a_split_grant: assert property (split && !arb_off && $stable(split) && $stable(arb_off)
      |-> !combined_grant_busy_oe)
    else $error("Combined line driven in split mode");
  a_ext_request: assert property (arb_off && !rst_arb && (dma_request || ide_request)
      |=> primary_bus_request)
    else $error("Primary request missing");
  a_usb_pair: assert property (arb_off && !rst_arb && sep && usb_request && !dma_request
      && !ide_request |=> secondary_bus_request && !primary_bus_request)
    else $error("USB not on secondary pair");
  a_park: assert property (arb_off && !rst_arb && primary_bus_grant && !prim_req
      |=> bus_parked && grant == '0)
    else $error("Parking not applied");
  a_pg_reset: assert property (!power_good |=> cpu_reset_out && logic_reset)
    else $error("Reset not applied without power-good");
  a_hold_reset: assert property ($rose(power_good) |-> cpu_reset_out [*8])
    else $error("CPU reset released too soon");
  a_ext_invert: assert property (power_good && ext_mode && hold_done && !pci_reset_line_in
      ##1 power_good |-> cpu_reset_out && isa_reset)
    else $error("External PCI reset not passed on");

  c_serve: cover property (state == ST_SAMPLE ##1 state == ST_SERVE);
  c_busy: cover property (state == ST_SAMPLE ##1 state == ST_BUSY ##1 state == ST_BUSY);
  c_three: cover property (serves == MAX_SERVES ##1 state == ST_BRIDGE);
  c_park: cover property (bus_parked);
endmodule

// *** bridge_model.sv ***
// Far-side model: CPU-to-PCI bridge and external PCI arbiter
`timescale 1ns/10ps
module bridge_model (
  input  wire logic aclk,
  input  wire logic split,
  input  wire logic keep,
  input  wire logic park,
  input  wire logic combined_grant_busy_out,
  input  wire logic combined_grant_busy_oe,
  input  wire logic bridge_grant,
  input  wire logic primary_bus_request,
  input  wire logic secondary_bus_request,
  output logic      combined_grant_busy_in,
  output logic      bridge_busy,
  output logic      primary_bus_grant,
  output logic      secondary_bus_grant
);
  logic [3:0] hold = 4'h0;
  logic       had = 1'h0;
  wire        drive = hold != 4'h0;
  wire        lost = split ? had && !bridge_grant : combined_grant_busy_oe && !combined_grant_busy_out;
  initial {primary_bus_grant, secondary_bus_grant} = 2'h0;
  // Fixed busy span stands in for the bus draining to idle
  always @(posedge aclk) begin
    if (lost && keep) hold <= 4'h6;
    else if (drive) hold <= hold - 4'h1;
    had <= bridge_grant;
    primary_bus_grant <= primary_bus_request || park;
    secondary_bus_grant <= secondary_bus_request;
  end
  // Released lines fall to their pull-downs, never hold a stale level
  assign combined_grant_busy_in = combined_grant_busy_oe ? combined_grant_busy_out : !split && drive;
  assign bridge_busy = split && drive;
endmodule

// *** testbench.sv ***
// Self-checking bench for the arbitration and reset block
`timescale 1ns/10ps
module testbench;
  import arb_pkg::*;
  localparam int HOLD = 20;
  logic        aclk = 1'h0, aresetn = 1'h0;
  logic [7:0]  awaddr = 8'h0, araddr = 8'h0;
  logic [31:0] wdata = 32'h0, rdata;
  logic [3:0]  wstrb = 4'hf;
  logic        awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0, rready = 1'h0;
  logic        awready, wready, bvalid, arready, rvalid, rtc_square_out, rtc_square_oe;
  logic [1:0]  bresp, rresp, master_grant, master_request = 2'h0;
  logic        arbiter_disable_strap = 1'h1, grant_busy_split_strap = 1'h1, reset_source_strap = 1'h1;
  logic        power_good = 1'h0, ext_rst = 1'h1, pci_reset_line_in, pci_reset_line_out, pci_reset_line_oe;
  logic        cpu_reset_out, logic_reset, isa_reset, dma_grant, ide_grant, usb_grant, bus_parked;
  logic        dma_request = 1'h0, ide_request = 1'h0, usb_request = 1'h0, rtc_square_in = 1'h0;
  logic        primary_bus_request, primary_bus_grant, secondary_bus_request, secondary_bus_grant;
  logic        combined_grant_busy_in, combined_grant_busy_out, combined_grant_busy_oe, bridge_grant, bridge_busy;
  logic        split = 1'h0, keep = 1'h0, park = 1'h0, rtc_exp = 1'h0;
  int          failures = 0, cmp_count = 0, seed = 81;
  wire [4:0]   gv = {master_grant, usb_grant, ide_grant, dma_grant};
  wire         bgrant = split ? bridge_grant : combined_grant_busy_out && combined_grant_busy_oe;
  logic [2:0]  own [4] = '{3'h1, 3'h4, 3'h2, 3'h4};

  standalone_pci_arbitration_reset #(.RESET_HOLD(HOLD)) i_dut (.*);
  bridge_model i_far (.*);
  // Pin level: device drives low, else the external agent or pull-up
  assign pci_reset_line_in = pci_reset_line_oe ? pci_reset_line_out : ext_rst;
  always #20 aclk = ~aclk;
  always @(posedge aclk) rtc_square_in <= 1'($random(seed));
  // Square wave passes through one register on its way to the pin
  always @(posedge aclk) rtc_exp <= rtc_square_in;
  always @(negedge aclk) begin
    if (aresetn && arbiter_disable_strap && gv != 5'h0) chk("busy_hold", 2'h0, {combined_grant_busy_in, bridge_busy});
    if (aresetn && rtc_square_oe) chk("rtc_out", rtc_exp, rtc_square_out);
  end
  initial begin
    #800000;
    failures++;
    summarize();
  end
  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      failures++;
      $display("[ERR] %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic summarize();
    if (failures == 0 && cmp_count > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge aclk);
  endtask
  task automatic axw(input logic [7:0] a, input logic [31:0] d, input logic [1:0] e);
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    bready <= 1'h1;
    do begin
      @(posedge aclk);
      if (awready) awvalid <= 1'h0;
      if (wready) wvalid <= 1'h0;
      if (bvalid && bready) begin
        bready <= 1'h0;
        chk("bresp", e, bresp);
      end
    end while (bready);
  endtask
  task automatic axr(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er, input logic [31:0] m);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'h1;
    rready <= 1'h1;
    do begin
      @(posedge aclk);
      if (arready) arvalid <= 1'h0;
      if (rvalid && rready) begin
        rready <= 1'h0;
        chk("rdata", e, rdata & m);
        chk("rresp", er, rresp);
      end
    end while (rready);
  endtask
  // Straps only count while power-good is low, so every mode change cycles it
  task automatic pwr(input logic [2:0] s);
    @(posedge aclk);
    {arbiter_disable_strap, grant_busy_split_strap, reset_source_strap} <= s;
    split <= !s[1];
    power_good <= 1'h0;
    cyc(4);
    chk("pg_low", {2'h3, s[0]}, {cpu_reset_out, logic_reset, pci_reset_line_oe});
    @(posedge aclk);
    power_good <= 1'h1;
    cyc(HOLD - 2);
    chk("pg_hold", {1'h1, s[0], 1'h0}, {cpu_reset_out, pci_reset_line_oe, pci_reset_line_out});
    cyc(6);
    chk("pg_rel", {3'h0, !s[2]}, {cpu_reset_out, pci_reset_line_oe, logic_reset, rtc_square_oe});
  endtask
  task automatic arb(input logic [4:0] r, input logic k);
    logic [4:0] p;
    logic [4:0] g;
    int n;
    p = r;
    @(posedge aclk);
    keep <= k;
    {master_request, usb_request, ide_request, dma_request} <= r;
    while (p != 5'h0) begin
      if (split) begin
        repeat (20) if (bridge_grant) @(negedge aclk);
        chk("split_rev", 2'h0, {bridge_grant, combined_grant_busy_oe});
      end else begin
        repeat (20) if (combined_grant_busy_out) @(negedge aclk);
        chk("revoke", 2'h1, {combined_grant_busy_out, combined_grant_busy_oe});
        cyc(1);
        chk("release", 1'h0, combined_grant_busy_oe);
      end
      for (n = 0; n < 3 && p != 5'h0; n++) begin
        repeat (40) if (gv == 5'h0) @(negedge aclk);
        g = p & -p;
        chk("grant", g, gv);
        @(posedge aclk);
        p = p & ~g;
        {master_request, usb_request, ide_request, dma_request} <= p;
        repeat (5) if (gv == g) @(negedge aclk);
      end
      repeat (40) if (!bgrant) @(negedge aclk);
      chk("regrant", 1'h1, bgrant);
    end
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    logic [31:0] d;
    logic [4:0]  r;
    repeat (16) @(posedge aclk);
    aresetn <= 1'h1;
    cyc(1);
    chk("idle", 6'h39, {awready, wready, arready, bvalid, rvalid, cpu_reset_out});
    pwr(3'h7);
    d = $random(seed);
    axw(CTRL_ADDR, d, RESP_OKAY);
    axw(8'h0c, 32'hffffffff, RESP_SLVERR);
    axr(CTRL_ADDR, {24'h0, d[7:0]}, RESP_OKAY, 32'hffffffff);
    axr(8'h08, 32'h0, RESP_SLVERR, 32'hffffffff);
    axr(STATUS_ADDR, 32'h0, RESP_OKAY, 32'hf);
    arb(5'h0f, 1'h0);
    r = 5'($random(seed));
    arb(r == 5'h0 ? 5'h1f : r, 1'h0);
    arb(5'h06, 1'h1);
    pwr(3'h5);
    arb(5'h18, 1'h0);
    arb(5'h1f, 1'h1);
    pwr(3'h3);
    axr(STATUS_ADDR, 32'h1, RESP_OKAY, 32'hf);
    for (int i = 0; i < 4; i++) begin
      axw(CTRL_ADDR, {24'h0, i[1], 7'h0}, RESP_OKAY);
      @(posedge aclk);
      {usb_request, ide_request, dma_request} <= own[i];
      repeat (20) if ({usb_grant, ide_grant, dma_grant} == 3'h0) @(negedge aclk);
      chk("ext_grant", own[i], {usb_grant, ide_grant, dma_grant});
      chk("ext_req", (i == 3) ? 2'h2 : 2'h1, {secondary_bus_request, primary_bus_request});
      @(posedge aclk);
      {usb_request, ide_request, dma_request} <= 3'h0;
      cyc(6);
    end
    @(posedge aclk);
    park <= 1'h1;
    cyc(4);
    chk("parked", 6'h20, {bus_parked, gv});
    @(posedge aclk);
    park <= 1'h0;
    pwr(3'h6);
    @(posedge aclk);
    ext_rst <= 1'h0;
    cyc(80);
    chk("ext_rst", 3'h7, {cpu_reset_out, logic_reset, isa_reset});
    @(posedge aclk);
    ext_rst <= 1'h1;
    cyc(4);
    chk("ext_rel", 3'h0, {cpu_reset_out, logic_reset, isa_reset});
    summarize();
  end
endmodule
